// ### core/gidp_edge.sv
`include "gidp_params.svh"

module gidp_edge #(
    parameter int WIDTH = `GIDP_NPINS,
    parameter int STAGES = 2
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pins and clean events
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] sync_ff [STAGES];
    logic [WIDTH-1:0] prev_ff;
    logic [STAGES:0] warm_ff;

    if (STAGES < 2)
    begin : g_chk
        $error("gidp_edge needs at least two synchroniser stages");
    end

    // Only the next stage reads sync_ff[0]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < STAGES; i++)
            begin
                sync_ff[i] <= '0;
            end
            prev_ff <= '0;
            warm_ff <= '0;
        end
        else
        begin
            sync_ff[0] <= raw;
            for (int i = 1; i < STAGES; i++)
            begin
                sync_ff[i] <= sync_ff[i-1];
            end
            prev_ff <= sync_ff[STAGES-1];
            warm_ff <= {warm_ff[STAGES-1:0], 1'b1};
        end
    end

    assign level = sync_ff[STAGES-1];
    // Masked until prev_ff holds a real pin level, so a pad idling high fakes no edge
    // after reset; a true edge inside that short window is lost
    assign rise = level & ~prev_ff & {WIDTH{warm_ff[STAGES]}};
    assign fall = ~level & prev_ff & {WIDTH{warm_ff[STAGES]}};

endmodule // gidp_edge

// ### core/gidp_params.svh
`ifndef GIDP_PARAMS_SVH
`define GIDP_PARAMS_SVH

// Register byte offsets
`define GIDP_OFS_DIR      8'h00
`define GIDP_OFS_FSEL     8'h04
`define GIDP_OFS_DOUT     8'h08
`define GIDP_OFS_PIN      8'h0C
`define GIDP_OFS_ICTL     8'h10
`define GIDP_OFS_P1EN     8'h14
`define GIDP_OFS_FLAGS    8'h18
`define GIDP_OFS_CPUEN    8'h1C
`define GIDP_OFS_CPUFLG   8'h20
`define GIDP_OFS_LOC      8'h24
`define GIDP_OFS_SLEEP    8'h28

// Fields of port_irq_control
`define GIDP_ICTL_EDGE0   0
`define GIDP_ICTL_EDGE1   1
`define GIDP_ICTL_EDGE2   2
`define GIDP_ICTL_P0LO    3
`define GIDP_ICTL_P0HI    4
`define GIDP_ICTL_P2EN    5
`define GIDP_ICTL_W       6

// Fields of the CPU enable and flag words, and location control
`define GIDP_CPU_P0       0
`define GIDP_CPU_P1       1
`define GIDP_CPU_P2       2
`define GIDP_LOC_SER0     0
`define GIDP_LOC_SER1     1

// Pin positions in the flat pin vector
`define GIDP_NPINS        21
`define GIDP_P1_BASE      8
`define GIDP_SER_A1_BASE  2
`define GIDP_SER0_A2_BASE 10
`define GIDP_SER1_A2_BASE 12
`define GIDP_DMA_A_PIN    1
`define GIDP_DMA_B_PIN    11

// Reset values and codes
`define GIDP_RST_PINS     21'h000000
`define GIDP_SLEEP_ACTIVE 2'h0
`define GIDP_RESP_OKAY    2'h0
`define GIDP_RESP_SLVERR  2'h2

`endif

// ### core/gidp_pkg.sv
package gidp_pkg;

    typedef struct packed {
        logic [4:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } gidp_pins_t;

    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } gidp_ser_t;

endpackage

// ### core/gidp_top.sv
`include "gidp_params.svh"

module gidp_top import gidp_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pads
    input wire gidp_pins_t pin_in,
    output gidp_pins_t pin_out,
    output gidp_pins_t pin_oe,
    // Peripherals
    input wire gidp_ser_t ser0_drive,
    input wire gidp_ser_t ser1_drive,
    output logic [3:0] ser0_din,
    output logic [3:0] ser1_din,
    output logic [7:0] adc_level,
    // Interrupts to the CPU and DMA triggers
    output logic [2:0] cpu_irq,
    output logic io_dma_trigger_a,
    output logic io_dma_trigger_b
);
    if (ADDR_W < 8)
    begin : g_chk
        $error("gidp_top address too narrow for the register map");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [`GIDP_NPINS-1:0] dir_ff, sel_ff, dout_ff, flags_ff;
    logic [`GIDP_NPINS-1:0] lvl, rise, fall, gp_in, ev, nxt_flags;
    logic [`GIDP_ICTL_W-1:0] ictl_ff;
    logic [7:0] port1_pin_irq_enables_ff;
    logic [2:0] cpuen_ff, cpuflg_ff, cpu_irq_ff, cpu_set, nxt_cpuflg;
    logic [1:0] loc_ff, sleep_ff;
    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff, wr_go, sleep_ok;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff, wr_cur, wr_merged, wr_mask;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic wr_hit;
    logic [32:0] rd_lookup;
    logic [`GIDP_NPINS-1:0] out_c, oe_c, out_ff, oe_ff;
    logic [3:0] ser0_din_ff, ser1_din_ff;
    logic dma_a_ff, dma_b_ff;

    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (st[b])
            begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Returns {hit, data}; unmapped offsets miss
    function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        unique case (a[7:0])
            `GIDP_OFS_DIR: r[20:0] = dir_ff;
            `GIDP_OFS_FSEL: r[20:0] = sel_ff;
            `GIDP_OFS_DOUT: r[20:0] = dout_ff;
            `GIDP_OFS_PIN: r[20:0] = lvl;
            `GIDP_OFS_ICTL: r[`GIDP_ICTL_W-1:0] = ictl_ff;
            `GIDP_OFS_P1EN: r[7:0] = port1_pin_irq_enables_ff;
            `GIDP_OFS_FLAGS: r[20:0] = flags_ff;
            `GIDP_OFS_CPUEN: r[2:0] = cpuen_ff;
            `GIDP_OFS_CPUFLG: r[2:0] = cpuflg_ff;
            `GIDP_OFS_LOC: r[1:0] = loc_ff;
            `GIDP_OFS_SLEEP: r[1:0] = sleep_ff;
            default: r = 33'h000000000;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: address and data may arrive in either order
    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign {wr_hit, wr_cur} = reg_read(awaddr_ff);
    assign wr_merged = byte_merge(wr_cur, wdata_ff, wstrb_ff);
    assign wr_mask = byte_merge(32'h00000000, wdata_ff, wstrb_ff);
    assign rd_lookup = reg_read(s_axi_araddr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `GIDP_RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `GIDP_RESP_OKAY : `GIDP_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `GIDP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_lookup[32] ? `GIDP_RESP_OKAY : `GIDP_RESP_SLVERR;
            rdata_ff <= rd_lookup[31:0];
        end
        else if (s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir_ff <= `GIDP_RST_PINS;
            sel_ff <= `GIDP_RST_PINS;
            dout_ff <= `GIDP_RST_PINS;
            ictl_ff <= '0;
            port1_pin_irq_enables_ff <= 8'h00;
            cpuen_ff <= 3'h0;
            loc_ff <= 2'h0;
            sleep_ff <= `GIDP_SLEEP_ACTIVE;
        end
        else if (wr_go)
        begin
            unique case (awaddr_ff[7:0])
                `GIDP_OFS_DIR: dir_ff <= wr_merged[20:0];
                `GIDP_OFS_FSEL: sel_ff <= wr_merged[20:0];
                `GIDP_OFS_DOUT: dout_ff <= wr_merged[20:0];
                `GIDP_OFS_ICTL: ictl_ff <= wr_merged[`GIDP_ICTL_W-1:0];
                `GIDP_OFS_P1EN: port1_pin_irq_enables_ff <= wr_merged[7:0];
                `GIDP_OFS_CPUEN: cpuen_ff <= wr_merged[2:0];
                `GIDP_OFS_LOC: loc_ff <= wr_merged[1:0];
                `GIDP_OFS_SLEEP: sleep_ff <= wr_merged[1:0];
                default:
                begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin events
    gidp_edge #(.WIDTH(`GIDP_NPINS), .STAGES(2)) u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(pin_in),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    assign gp_in = ~dir_ff & ~sel_ff;
    assign ev = gp_in & {ictl_ff[`GIDP_ICTL_EDGE2] ? fall[20:16] : rise[20:16],
                         ictl_ff[`GIDP_ICTL_EDGE1] ? fall[15:8] : rise[15:8],
                         ictl_ff[`GIDP_ICTL_EDGE0] ? fall[7:0] : rise[7:0]};
    assign sleep_ok = (sleep_ff == `GIDP_SLEEP_ACTIVE);

    // Set wins over a same-cycle clear; flags set even with the pin disabled
    assign nxt_flags = (flags_ff & ~((wr_go && awaddr_ff[7:0] == `GIDP_OFS_FLAGS) ? wr_mask[20:0]
                        : `GIDP_RST_PINS)) | ev;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_ff <= `GIDP_RST_PINS;
        end
        else
        begin
            flags_ff <= nxt_flags;
        end
    end

    // Level-sensitive set: an uncleared pin flag re-raises the CPU flag
    assign cpu_set[`GIDP_CPU_P0] = |(flags_ff[7:0] & {{4{ictl_ff[`GIDP_ICTL_P0HI]}},
                                                      {4{ictl_ff[`GIDP_ICTL_P0LO]}}});
    assign cpu_set[`GIDP_CPU_P1] = |(flags_ff[15:8] & port1_pin_irq_enables_ff);
    assign cpu_set[`GIDP_CPU_P2] = |flags_ff[20:16] & ictl_ff[`GIDP_ICTL_P2EN];
    assign nxt_cpuflg = (cpuflg_ff & ~((wr_go && awaddr_ff[7:0] == `GIDP_OFS_CPUFLG) ? wr_mask[2:0]
                        : 3'h0)) | (cpu_set & {3{sleep_ok}});

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpuflg_ff <= 3'h0;
            cpu_irq_ff <= 3'h0;
        end
        else
        begin
            cpuflg_ff <= nxt_cpuflg;
            cpu_irq_ff <= cpuflg_ff & cpuen_ff & {3{sleep_ok}};
        end
    end

    assign cpu_irq = cpu_irq_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_a_ff <= 1'b0;
            dma_b_ff <= 1'b0;
        end
        else
        begin
            dma_a_ff <= rise[`GIDP_DMA_A_PIN] & gp_in[`GIDP_DMA_A_PIN];
            dma_b_ff <= fall[`GIDP_DMA_B_PIN] & gp_in[`GIDP_DMA_B_PIN];
        end
    end

    assign io_dma_trigger_a = dma_a_ff;
    assign io_dma_trigger_b = dma_b_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin mux; serial unit 0 wins a shared pin, other units have no precedence logic
    always_comb
    begin
        int i0, i1;
        i0 = 0;
        i1 = 0;
        out_c = dout_ff;
        oe_c = dir_ff & ~sel_ff;
        for (int k = 0; k < 4; k++)
        begin
            i1 = loc_ff[`GIDP_LOC_SER1] ? `GIDP_SER1_A2_BASE + k : `GIDP_SER_A1_BASE + k;
            i0 = loc_ff[`GIDP_LOC_SER0] ? `GIDP_SER0_A2_BASE + k : `GIDP_SER_A1_BASE + k;
            if (sel_ff[i1])
            begin
                out_c[i1] = ser1_drive.dout[k];
                oe_c[i1] = ser1_drive.oe[k];
            end
            if (sel_ff[i0])
            begin
                out_c[i0] = ser0_drive.dout[k];
                oe_c[i0] = ser0_drive.oe[k];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_ff <= `GIDP_RST_PINS;
            oe_ff <= `GIDP_RST_PINS;
            ser0_din_ff <= 4'h0;
            ser1_din_ff <= 4'h0;
        end
        else
        begin
            out_ff <= out_c;
            oe_ff <= oe_c;
            for (int k = 0; k < 4; k++)
            begin
                ser0_din_ff[k] <= loc_ff[`GIDP_LOC_SER0] ? lvl[`GIDP_SER0_A2_BASE + k]
                                  : lvl[`GIDP_SER_A1_BASE + k];
                ser1_din_ff[k] <= loc_ff[`GIDP_LOC_SER1] ? lvl[`GIDP_SER1_A2_BASE + k]
                                  : lvl[`GIDP_SER_A1_BASE + k];
            end
        end
    end

    assign pin_out = out_ff;
    assign pin_oe = oe_ff;
    assign ser0_din = ser0_din_ff;
    assign ser1_din = ser1_din_ff;
    assign adc_level = lvl[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_flag_on_edge: assert property (|ev |=> ((flags_ff & $past(ev)) == $past(ev)))
        else $error("pin flag missed an edge");
    a_edge_select: assert property ($rose(flags_ff[2]) |-> $past(gp_in[2]
        && (ictl_ff[`GIDP_ICTL_EDGE0] ? fall[2] : rise[2])))
        else $error("pin flag set without a selected edge");
    a_cpu_flag_cause: assert property ($rose(cpuflg_ff[`GIDP_CPU_P1]) |->
        $past(|(flags_ff[15:8] & port1_pin_irq_enables_ff)))
        else $error("port 1 cpu flag set without enabled pin flag");
    a_nibble_gate: assert property ((!ictl_ff[`GIDP_ICTL_P0LO] && !ictl_ff[`GIDP_ICTL_P0HI]
        && !cpuflg_ff[`GIDP_CPU_P0]) |=> !cpuflg_ff[`GIDP_CPU_P0])
        else $error("port 0 cpu flag set with both nibbles disabled");
    a_sleep_block: assert property (!sleep_ok [*2] |-> cpu_irq == 3'h0)
        else $error("port interrupt reached cpu during sleep");
    a_dma_a_rise: assert property ((rise[1] && gp_in[1]) |=> io_dma_trigger_a ##1 !io_dma_trigger_a)
        else $error("trigger A not a single pulse after rise");
    a_dma_b_fall: assert property ((fall[11] && gp_in[11]) |=> io_dma_trigger_b)
        else $error("trigger B missed a fall");
    a_dma_only_gpin: assert property (io_dma_trigger_a |-> $past(!sel_ff[1] && !dir_ff[1]))
        else $error("trigger A from a non-input pin");
    a_dir_drives: assert property ((dir_ff[1] && !sel_ff[1]) |=> pin_oe[1])
        else $error("output pin not driven");
    a_ser0_alt2: assert property ((sel_ff[10] && loc_ff[0] && ser0_drive.oe[0]) |=> pin_oe[10])
        else $error("serial 0 alternative 2 not routed");

    c_dma_a: cover property (io_dma_trigger_a);
    c_cpu_irq_p1: cover property (cpu_irq[`GIDP_CPU_P1]);
    c_flag_clear: cover property (flags_ff[11] ##1 !flags_ff[11]);
    c_ser1_alt2: cover property (sel_ff[12] && loc_ff[1]);

endmodule // gidp_top

// ### verif/gidp_pads.sv
module gidp_pads import gidp_pkg::*;
(
    // Device side of each pad
    input wire gidp_pins_t pin_out,
    input wire gidp_pins_t pin_oe,
    // Board side drive
    input wire gidp_pins_t ext,
    // Level seen on each pad
    output gidp_pins_t pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // The device wins where it drives; the board holds every released pad
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // gidp_pads

// ### verif/gidp_top_bench.sv
`include "gidp_params.svh"

module gidp_top_bench import gidp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, trig_a, trig_b;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, adc;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, s0_din, s1_din;
    logic [1:0] bresp, rresp;
    logic [2:0] cpu_irq;
    logic [33:0] na = '0, nb = '0;
    logic [33:0] exq[$];
    logic [7:0] d;
    logic [31:0] x, y;
    gidp_pins_t pin_in, pin_out, pin_oe, e;
    gidp_pins_t ext = 21'h000800;
    gidp_ser_t s0 = 8'h00, s1 = 8'h00;
    int mismatches = 0, compares = 0;
    integer seed = 32'h8D94DA21;

    always #2.5 aclk = ~aclk;

    gidp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .ser0_drive(s0), .ser1_drive(s1), .ser0_din(s0_din),
        .ser1_din(s1_din), .adc_level(adc), .cpu_irq(cpu_irq), .io_dma_trigger_a(trig_a),
        .io_dma_trigger_b(trig_b));

    gidp_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            close_out();
        end
    endtask

    // Expected read answers queue up here; the watcher below pairs them in order
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = 2'h0);
        int n;
        exq.push_back({r, v});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        if (n == 50)
        begin
            mismatches++;
            close_out();
        end
    endtask

    // Two sync stages plus the flag stage need well under six edges
    task automatic pad(input gidp_pins_t v);
        @(posedge aclk);
        ext <= v;
        repeat (6) @(posedge aclk);
    endtask

    always @(posedge aclk)
    begin
        if (trig_a)
            na <= na + 1;
        if (trig_b)
            nb <= nb + 1;
        if (rvalid && rready)
            chk({rresp, rdata}, exq.pop_front());
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        e = ext;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`GIDP_OFS_DIR, 32'h0);
        rd(`GIDP_OFS_FSEL, 32'h0);
        rd(`GIDP_OFS_ICTL, 32'h0);
        rd(`GIDP_OFS_FLAGS, 32'h0);
        rd(`GIDP_OFS_CPUEN, 32'h0);
        rd(`GIDP_OFS_CPUFLG, 32'h0);
        rd(8'h2C, 32'h0, `GIDP_RESP_SLVERR);
        e.p0[1] = 1'b1;
        pad(e);
        chk(na, 1);
        rd(`GIDP_OFS_FLAGS, 32'h2);
        e.p1[3] = 1'b0;
        pad(e);
        chk(nb, 1);
        rd(`GIDP_OFS_FLAGS, 32'h2);
        wr(`GIDP_OFS_ICTL, 32'h2);
        e.p1[3] = 1'b1;
        pad(e);
        e.p1[3] = 1'b0;
        pad(e);
        chk(nb, 2);
        rd(`GIDP_OFS_FLAGS, 32'h802);
        wr(`GIDP_OFS_FLAGS, 32'hFFFFFFFF);
        rd(`GIDP_OFS_FLAGS, 32'h0);
        // Peripheral pin edge, then output activity, must stay silent
        e.p0[1] = 1'b0;
        pad(e);
        wr(`GIDP_OFS_FSEL, 32'h2);
        e.p0[1] = 1'b1;
        pad(e);
        wr(`GIDP_OFS_FSEL, 32'h0);
        wr(`GIDP_OFS_DIR, 32'h2);
        pad(e);
        wr(`GIDP_OFS_DOUT, 32'h2);
        pad(e);
        wr(`GIDP_OFS_DIR, 32'h0);
        pad(e);
        chk(na, 1);
        rd(`GIDP_OFS_FLAGS, 32'h0);
        wr(`GIDP_OFS_CPUEN, 32'h7);
        wr(`GIDP_OFS_ICTL, 32'h0A);
        e.p0[2] = 1'b1;
        e.p2[0] = 1'b1;
        pad(e);
        rd(`GIDP_OFS_FLAGS, 32'h10004);
        chk(cpu_irq, 3'h1);
        wr(`GIDP_OFS_SLEEP, 32'h1);
        pad(e);
        chk(cpu_irq, 3'h0);
        wr(`GIDP_OFS_SLEEP, 32'h0);
        pad(e);
        chk(cpu_irq, 3'h1);
        wr(`GIDP_OFS_FLAGS, 32'h4);
        wr(`GIDP_OFS_CPUFLG, 32'h1);
        pad(e);
        chk(cpu_irq, 3'h0);
        rd(`GIDP_OFS_CPUFLG, 32'h0);
        wr(`GIDP_OFS_ICTL, 32'h2A);
        pad(e);
        chk(cpu_irq, 3'h4);
        wr(`GIDP_OFS_CPUFLG, 32'h4);
        pad(e);
        chk(cpu_irq, 3'h4);
        wr(`GIDP_OFS_FLAGS, 32'h10000);
        wr(`GIDP_OFS_CPUFLG, 32'h4);
        pad(e);
        chk(cpu_irq, 3'h0);
        wr(`GIDP_OFS_P1EN, 32'h8);
        e.p1[3] = 1'b1;
        pad(e);
        e.p1[3] = 1'b0;
        pad(e);
        chk(nb, 3);
        rd(`GIDP_OFS_CPUFLG, 32'h2);
        // High nibble enable alone must ignore a low nibble flag
        wr(`GIDP_OFS_ICTL, 32'h12);
        e.p0[2] = 1'b0;
        pad(e);
        e.p0[2] = 1'b1;
        pad(e);
        chk(cpu_irq, 3'h2);
        e.p0[6] = 1'b1;
        pad(e);
        chk(cpu_irq, 3'h3);
        d = $random(seed);
        wr(`GIDP_OFS_DIR, 32'hFF);
        wr(`GIDP_OFS_DOUT, {24'h0, d});
        pad(e);
        chk(pin_out.p0, d);
        chk(pin_oe, 21'hFF);
        rd(`GIDP_OFS_PIN, {11'h0, e.p2, e.p1, d});
        wr(`GIDP_OFS_DIR, 32'h0);
        x = $random(seed);
        y = $random(seed);
        @(posedge aclk);
        s0 <= {x[3:0], 4'hF};
        s1 <= {y[3:0], 4'hF};
        wr(`GIDP_OFS_LOC, 32'h0);
        wr(`GIDP_OFS_FSEL, 32'h3C);
        pad(e);
        chk(pin_out.p0[5:2], x[3:0]);
        chk(pin_oe, 21'h3C);
        chk(s0_din, x[3:0]);
        chk(s1_din, x[3:0]);
        wr(`GIDP_OFS_LOC, 32'h3);
        wr(`GIDP_OFS_FSEL, 32'hFC00);
        pad(e);
        chk(pin_out.p1[7:2], {y[3:2], x[3:0]});
        chk(pin_oe, 21'hFC00);
        chk(s0_din, x[3:0]);
        chk(s1_din, {y[3:2], x[3:2]});
        chk(adc, e.p0);
        close_out();
    end
endmodule // gidp_top_bench
